// file: hdl/fsb_dev.sv
// Processor end: drives data phases and follows the deep-sleep request
// Function
// - data driver holds bus busy throughout
// - data driver marks each valid transfer
// - idle clocks inside transfer; receivers skip them
// - driver sends four parity lines over data
// - deep-sleep request in Sleep enters Deep Sleep
// - platform releases request, bus clock running
// - processor provides debug reset output
// - per-group inversion flag when mostly low
// - four words per bus clock, strobe-latched
`timescale 1ns/10ps
`include "fsb_cfg.svh"
module fsb_dev
  import fsb_pkg::*;
#(
  parameter int XFER_BCLKS = `FSB_XFER_BCLKS,
  parameter int FIFO_DEPTH = `FSB_FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire fsb_word_t   tx_data_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  input  wire logic        sleep_req_in,
  input  wire logic        dbg_reset_req_in,
  output fsb_pwr_e         pwr_state_out,
  output logic             xfer_active_out,
  fsb_if.dev               bus
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  generate
    if (XFER_BCLKS < 1 || XFER_BCLKS > 255 || FIFO_DEPTH < `FSB_WORDS_PER_BCLK) begin : g_bad
      $error("fsb_dev needs 1..255 bus clocks per transfer and a FIFO of 4 words or more");
    end
    if (`FSB_BCLK_CYC != 8) begin : g_bad_clk
      $error("fsb_dev sub-phase sequencer assumes eight clocks per bus clock");
    end
  endgenerate

  // Transmit FIFO
  fsb_word_t       fifo_data;
  logic            fifo_valid;
  logic            fifo_pop;
  logic [LW-1:0]   fifo_level;

  fsb_fifo #(
    .WIDTH (`FSB_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_data_in    (tx_data_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .level_out     (fifo_level)
  );

  // Pin synchronisers
  logic            bclk_s1_r;
  logic            bclk_s2_r;
  logic            bclk_s3_r;
  logic            deep_sleep_request_n_s1_r;
  logic            deep_sleep_request_n_s2_r;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bclk_s1_r  <= 1'b0;
      bclk_s2_r  <= 1'b0;
      bclk_s3_r  <= 1'b0;
      deep_sleep_request_n_s1_r <= `FSB_PIN_IDLE;
      deep_sleep_request_n_s2_r <= `FSB_PIN_IDLE;
    end else begin
      bclk_s1_r  <= bus.bclk;
      bclk_s2_r  <= bclk_s1_r;
      bclk_s3_r  <= bclk_s2_r;
      deep_sleep_request_n_s1_r <= bus.deep_sleep_request_n;
      deep_sleep_request_n_s2_r <= deep_sleep_request_n_s1_r;
    end
  end

  logic bclk_rise;
  logic bclk_edge;
  assign bclk_rise = bclk_s2_r & ~bclk_s3_r;
  assign bclk_edge = bclk_s2_r ^ bclk_s3_r;

  // Power state and bus clock activity
  fsb_pwr_e        pwr_r;
  fsb_pwr_e        pwr_nxt;
  logic [4:0]      live_cnt_r;
  logic [4:0]      live_cnt_nxt;
  logic            bclk_live;
  logic            dbr_n_r;
  logic            dbr_n_nxt;
  logic            busy_r;

  always_comb begin
    live_cnt_nxt = live_cnt_r;
    if (bclk_edge) begin
      live_cnt_nxt = '0;
    end else if (live_cnt_r != 5'h1F) begin
      live_cnt_nxt = live_cnt_r + 5'h01;
    end
    bclk_live = (live_cnt_r < 5'(`FSB_BCLK_LIVE_CYC));
    dbr_n_nxt = ~dbg_reset_req_in;
    pwr_nxt   = pwr_r;
    unique case (pwr_r)
      FSB_PWR_RUN: begin
        if (sleep_req_in && !busy_r) begin
          pwr_nxt = FSB_PWR_SLEEP;
        end
      end
      FSB_PWR_SLEEP: begin
        if (!deep_sleep_request_n_s2_r) begin
          pwr_nxt = FSB_PWR_DEEP;
        end else if (!sleep_req_in) begin
          pwr_nxt = FSB_PWR_RUN;
        end
      end
      FSB_PWR_DEEP: begin
        if (deep_sleep_request_n_s2_r && bclk_live) begin
          pwr_nxt = FSB_PWR_SLEEP;
        end
      end
      default: pwr_nxt = FSB_PWR_SLEEP;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pwr_r      <= FSB_PWR_RUN;
      live_cnt_r <= 5'h1F;
      dbr_n_r    <= 1'b1;
    end else begin
      pwr_r      <= pwr_nxt;
      live_cnt_r <= live_cnt_nxt;
      dbr_n_r    <= dbr_n_nxt;
    end
  end

  // Data phase sequencer
  logic            beat_r;
  logic            beat_nxt;
  logic [2:0]      cnt_r;
  logic [2:0]      cnt_nxt;
  logic [7:0]      left_r;
  logic [7:0]      left_nxt;
  logic            busy_nxt;
  logic            start_beat;
  logic            beat_end;
  logic [3:0]      stbp_r;
  logic [3:0]      stbp_nxt;
  logic [3:0]      stbn_r;
  logic [3:0]      stbn_nxt;

  always_comb begin
    beat_end   = beat_r && (cnt_r == 3'h7);
    start_beat = bclk_rise && (pwr_r == FSB_PWR_RUN) && (!beat_r || beat_end)
                 && (fifo_level >= LW'(`FSB_WORDS_PER_BCLK));
    beat_nxt   = beat_r;
    cnt_nxt    = beat_r ? cnt_r + 3'h1 : 3'h0;
    left_nxt   = left_r;
    busy_nxt   = busy_r;
    if (beat_end) begin
      beat_nxt = 1'b0;
      left_nxt = left_r - 8'h01;
      if (left_r == 8'h01) begin
        busy_nxt = 1'b0;
      end
    end
    if (start_beat) begin
      beat_nxt = 1'b1;
      cnt_nxt  = 3'h0;
      busy_nxt = 1'b1;
      if (!busy_r || (beat_end && left_r == 8'h01)) begin
        left_nxt = 8'(XFER_BCLKS);
      end
    end
    // Idle bus clocks inside a transfer leave valid deasserted
    fifo_pop = start_beat || (beat_r && cnt_r[0] && cnt_r != 3'h7);
    stbp_nxt = {4{~(beat_nxt && (cnt_nxt == `FSB_STB_P_LOW_A
                                 || cnt_nxt == `FSB_STB_P_LOW_B))}};
    stbn_nxt = {4{~(beat_nxt && (cnt_nxt == `FSB_STB_N_LOW_A
                                 || cnt_nxt == `FSB_STB_N_LOW_B))}};
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      beat_r <= 1'b0;
      cnt_r  <= 3'h0;
      left_r <= 8'h00;
      busy_r <= 1'b0;
      stbp_r <= 4'hF;
      stbn_r <= 4'hF;
    end else begin
      beat_r <= beat_nxt;
      cnt_r  <= cnt_nxt;
      left_r <= left_nxt;
      busy_r <= busy_nxt;
      stbp_r <= stbp_nxt;
      stbn_r <= stbn_nxt;
    end
  end

  // Word encoding: inversion and parity per 16-bit group
  fsb_word_t       enc_data;
  logic [3:0]      enc_inv;
  logic [3:0]      enc_par;
  fsb_word_t       data_n_r;
  fsb_word_t       data_n_nxt;
  logic [3:0]      dbi_n_r;
  logic [3:0]      dbi_n_nxt;
  logic [3:0]      par_n_r;
  logic [3:0]      par_n_nxt;

  genvar g;
  generate
    for (g = 0; g < `FSB_NGRP; g++) begin : g_grp
      logic [`FSB_GRP_W-1:0] word_grp;
      assign word_grp = fifo_data[g*`FSB_GRP_W +: `FSB_GRP_W];
      // A logic one drives the line low; invert when most lines would go low
      assign enc_inv[g] = ($countones(word_grp) > (`FSB_GRP_W / 2));
      assign enc_data[g*`FSB_GRP_W +: `FSB_GRP_W] =
        enc_inv[g] ? word_grp : ~word_grp;
      assign enc_par[g] = ^enc_data[g*`FSB_GRP_W +: `FSB_GRP_W];
    end
  endgenerate

  always_comb begin
    data_n_nxt = data_n_r;
    dbi_n_nxt  = dbi_n_r;
    par_n_nxt  = par_n_r;
    if (fifo_pop && fifo_valid) begin
      data_n_nxt = enc_data;
      dbi_n_nxt  = ~enc_inv;
      par_n_nxt  = enc_par;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      data_n_r <= '1;
      dbi_n_r  <= 4'hF;
      par_n_r  <= 4'hF;
    end else begin
      data_n_r <= data_n_nxt;
      dbi_n_r  <= dbi_n_nxt;
      par_n_r  <= par_n_nxt;
    end
  end

  assign bus.data_bus_busy_n     = ~busy_r;
  assign bus.data_valid_n        = ~beat_r;
  assign bus.data_n              = data_n_r;
  assign bus.data_parity_n       = par_n_r;
  assign bus.group_invert_flag_n = dbi_n_r;
  assign bus.data_strobe_pos_n   = stbp_r;
  assign bus.data_strobe_neg_n   = stbn_r;
  assign bus.debug_reset_out_n   = dbr_n_r;
  assign pwr_state_out           = pwr_r;
  assign xfer_active_out         = busy_r;
endmodule

// file: hdl/fsb_cfg.svh
// Timing, layout and reset constants of the data-phase link
`ifndef FSB_CFG_SVH
`define FSB_CFG_SVH

`define FSB_CLK_PERIOD_NS    40
`define FSB_BCLK_PERIOD_NS   320
`define FSB_BCLK_CYC         (`FSB_BCLK_PERIOD_NS / `FSB_CLK_PERIOD_NS)
`define FSB_BCLK_HALF_CYC    (`FSB_BCLK_CYC / 2)
`define FSB_WORDS_PER_BCLK   4
`define FSB_SUBPH_CYC        (`FSB_BCLK_CYC / `FSB_WORDS_PER_BCLK)
`define FSB_BCLK_LIVE_CYC    (2 * `FSB_BCLK_CYC)
`define FSB_DATA_W           64
`define FSB_GRP_W            16
`define FSB_NGRP             4
`define FSB_XFER_BCLKS       2
`define FSB_FIFO_DEPTH       8
`define FSB_STB_P_LOW_A      3'h1
`define FSB_STB_P_LOW_B      3'h5
`define FSB_STB_N_LOW_A      3'h3
`define FSB_STB_N_LOW_B      3'h7
`define FSB_PIN_IDLE         1'b1

`endif

// file: hdl/fsb_pkg.sv
// Types shared by both ends of the data-phase link
package fsb_pkg;

  typedef enum logic [1:0] {
    FSB_PWR_RUN   = 2'b00,
    FSB_PWR_SLEEP = 2'b01,
    FSB_PWR_DEEP  = 2'b10
  } fsb_pwr_e;

  typedef logic [63:0] fsb_word_t;

endpackage

// file: hdl/fsb_if.sv
// Pin-level connection between the processor end and the chipset end
`timescale 1ns/10ps
interface fsb_if;
  logic        bclk;
  logic        data_bus_busy_n;
  logic        data_valid_n;
  logic [63:0] data_n;
  logic [3:0]  data_parity_n;
  logic [3:0]  group_invert_flag_n;
  logic [3:0]  data_strobe_pos_n;
  logic [3:0]  data_strobe_neg_n;
  logic        deep_sleep_request_n;
  logic        debug_reset_out_n;

  modport dev (
    input  bclk,
    input  deep_sleep_request_n,
    output data_bus_busy_n,
    output data_valid_n,
    output data_n,
    output data_parity_n,
    output group_invert_flag_n,
    output data_strobe_pos_n,
    output data_strobe_neg_n,
    output debug_reset_out_n
  );

  modport host (
    output bclk,
    output deep_sleep_request_n,
    input  data_bus_busy_n,
    input  data_valid_n,
    input  data_n,
    input  data_parity_n,
    input  group_invert_flag_n,
    input  data_strobe_pos_n,
    input  data_strobe_neg_n,
    input  debug_reset_out_n
  );
endinterface

// file: hdl/fsb_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill level
`timescale 1ns/10ps
module fsb_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic [WIDTH-1:0]         in_data_in,
  input  wire logic                     in_valid_in,
  output logic                          in_ready_out,
  output logic [WIDTH-1:0]              out_data_out,
  output logic                          out_valid_out,
  input  wire logic                     out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0]    level_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("fsb_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    wr_nxt;
  logic [AW-1:0]    rd_r;
  logic [AW-1:0]    rd_nxt;
  logic [LW-1:0]    lvl_r;
  logic [LW-1:0]    lvl_nxt;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready_out  = (lvl_r != LW'(DEPTH));
    out_valid_out = (lvl_r != '0);
    push          = in_valid_in & in_ready_out;
    pop           = out_ready_in & out_valid_out;
    wr_nxt        = push ? wr_r + 1'b1 : wr_r;
    rd_nxt        = pop ? rd_r + 1'b1 : rd_r;
    lvl_nxt       = lvl_r + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_r  <= '0;
      rd_r  <= '0;
      lvl_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end

  assign out_data_out = mem_r[rd_r];
  assign level_out    = lvl_r;
endmodule

// file: hdl/fsb_host.sv
// Chipset end: makes the bus clock, receives data phases, drives deep sleep
`timescale 1ns/10ps
`include "fsb_cfg.svh"
module fsb_host
  import fsb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        deep_sleep_request_n_req_in,
  input  wire logic        bclk_stop_in,
  output fsb_word_t        rx_data_out,
  output logic             rx_valid_out,
  output logic             parity_err_out,
  output logic             bus_busy_out,
  output logic             dbg_reset_seen_out,
  fsb_if.host              bus
);
  localparam int SW = 2 + 4 * `FSB_NGRP + `FSB_DATA_W;

  // Bus clock divider; the request is only released with the clock running
  logic [2:0]      div_r;
  logic [2:0]      div_nxt;
  logic            bclk_r;
  logic            bclk_nxt;
  logic            deep_sleep_request_n_n_r;
  logic            deep_sleep_request_n_n_nxt;
  logic            bclk_run;

  always_comb begin
    bclk_run    = !(bclk_stop_in && deep_sleep_request_n_req_in);
    deep_sleep_request_n_n_nxt = ~deep_sleep_request_n_req_in;
    div_nxt     = div_r;
    bclk_nxt    = bclk_r;
    if (bclk_run) begin
      if (div_r == 3'(`FSB_BCLK_HALF_CYC - 1)) begin
        div_nxt  = 3'h0;
        bclk_nxt = ~bclk_r;
      end else begin
        div_nxt  = div_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      div_r     <= 3'h0;
      bclk_r    <= 1'b0;
      deep_sleep_request_n_n_r <= `FSB_PIN_IDLE;
    end else begin
      div_r     <= div_nxt;
      bclk_r    <= bclk_nxt;
      deep_sleep_request_n_n_r <= deep_sleep_request_n_n_nxt;
    end
  end

  // Two-stage synchronisers on every incoming pin, third stage for strobes
  logic [SW-1:0]   pin_s1_r;
  logic [SW-1:0]   pin_s2_r;
  logic [3:0]      stbp_s3_r;
  logic [3:0]      stbn_s3_r;
  logic            dbr_s1_r;
  logic            dbr_s2_r;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_s1_r  <= '1;
      pin_s2_r  <= '1;
      stbp_s3_r <= 4'hF;
      stbn_s3_r <= 4'hF;
      dbr_s1_r  <= 1'b1;
      dbr_s2_r  <= 1'b1;
    end else begin
      pin_s1_r  <= {bus.data_bus_busy_n, bus.data_valid_n, bus.data_strobe_pos_n,
                    bus.data_strobe_neg_n, bus.group_invert_flag_n,
                    bus.data_parity_n, bus.data_n};
      pin_s2_r  <= pin_s1_r;
      stbp_s3_r <= pin_s2_r[SW-3 -: 4];
      stbn_s3_r <= pin_s2_r[SW-7 -: 4];
      dbr_s1_r  <= bus.debug_reset_out_n;
      dbr_s2_r  <= dbr_s1_r;
    end
  end

  logic            busy_n_s;
  logic            data_valid_n_n_s;
  logic [3:0]      stbp_s;
  logic [3:0]      stbn_s;
  logic [3:0]      dbi_n_s;
  logic [3:0]      par_n_s;
  fsb_word_t       data_n_s;
  assign {busy_n_s, data_valid_n_n_s, stbp_s, stbn_s, dbi_n_s, par_n_s, data_n_s} = pin_s2_r;

  // Per-group decode; every group is taken on the group 0 strobe pair
  logic [3:0]      grp_fall;
  logic [3:0]      grp_perr;
  fsb_word_t       dec_data;

  genvar g;
  generate
    for (g = 0; g < `FSB_NGRP; g++) begin : g_grp
      logic [`FSB_GRP_W-1:0] pins;
      assign pins = data_n_s[g*`FSB_GRP_W +: `FSB_GRP_W];
      assign grp_fall[g] = (stbp_s3_r[g] & ~stbp_s[g]) | (stbn_s3_r[g] & ~stbn_s[g]);
      assign dec_data[g*`FSB_GRP_W +: `FSB_GRP_W] = dbi_n_s[g] ? ~pins : pins;
      assign grp_perr[g] = (^pins) ^ par_n_s[g];
    end
  endgenerate

  fsb_word_t       rx_data_r;
  fsb_word_t       rx_data_nxt;
  logic            rx_valid_r;
  logic            rx_valid_nxt;
  logic            perr_r;
  logic            perr_nxt;
  logic            take;

  always_comb begin
    // Strobe edges while valid is deasserted are idle clocks
    take         = grp_fall[0] && !data_valid_n_n_s;
    rx_valid_nxt = take;
    rx_data_nxt  = take ? dec_data : rx_data_r;
    perr_nxt     = take ? (|grp_perr) : perr_r;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_data_r  <= '0;
      rx_valid_r <= 1'b0;
      perr_r     <= 1'b0;
    end else begin
      rx_data_r  <= rx_data_nxt;
      rx_valid_r <= rx_valid_nxt;
      perr_r     <= perr_nxt;
    end
  end

  assign bus.bclk                 = bclk_r;
  assign bus.deep_sleep_request_n = deep_sleep_request_n_n_r;
  assign rx_data_out              = rx_data_r;
  assign rx_valid_out             = rx_valid_r;
  assign parity_err_out           = perr_r;
  assign bus_busy_out             = ~busy_n_s;
  assign dbg_reset_seen_out       = ~dbr_s2_r;
endmodule

// file: bench/fsb_chk.sv
// Concurrent checks on the pins of the data-phase link
`timescale 1ns/10ps
module fsb_chk (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        bclk,
  input  wire logic        data_bus_busy_n,
  input  wire logic        data_valid_n,
  input  wire logic [63:0] data_n,
  input  wire logic [3:0]  data_parity_n,
  input  wire logic [3:0]  group_invert_flag_n,
  input  wire logic [3:0]  data_strobe_pos_n,
  input  wire logic [3:0]  data_strobe_neg_n,
  input  wire logic        deep_sleep_request_n
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [3:0] par_exp;
  logic       strobe_any;

  always_comb begin
    for (int g = 0; g < 4; g++) par_exp[g] = ^data_n[16*g +: 16];
  end
  assign strobe_any = !data_strobe_pos_n[0] || !data_strobe_neg_n[0];

  // No group may put more than half of its pins low
  function automatic logic inv_ok(input logic [63:0] d, input logic [3:0] f);
    inv_ok = 1'b1;
    for (int g = 0; g < 4; g++) begin
      if ($countones(d[16*g +: 16]) < (f[g] ? 8 : 9)) inv_ok = 1'b0;
    end
  endfunction

  a_valid_in_busy:
    assert property (!data_valid_n |-> !data_bus_busy_n)
    else $error("valid low while bus not busy");
  a_busy_two_beats:
    assert property ($fell(data_bus_busy_n) |-> !data_bus_busy_n [*8] ##1 !data_bus_busy_n [*8])
    else $error("busy released before two beats");
  a_valid_eight_clk:
    assert property ($fell(data_valid_n) |-> !data_valid_n [*8])
    else $error("valid shorter than one bus clock");
  a_idle_quiet:
    assert property (data_bus_busy_n |-> data_valid_n && (&data_strobe_pos_n) && (&data_strobe_neg_n))
    else $error("valid or strobe active while bus idle");
  a_strobe_order:
    assert property ($fell(data_valid_n) |-> ##1 !data_strobe_pos_n[0] ##2 !data_strobe_neg_n[0]
                     ##2 !data_strobe_pos_n[0] ##2 !data_strobe_neg_n[0])
    else $error("strobe sequence wrong within beat");
  a_strobe_one_clk:
    assert property (strobe_any |=> data_strobe_pos_n[0] && data_strobe_neg_n[0])
    else $error("strobe pulse longer than one clock");
  a_strobe_groups:
    assert property (data_strobe_pos_n inside {4'h0, 4'hF} && data_strobe_neg_n inside {4'h0, 4'hF})
    else $error("group strobes disagree");
  a_strobe_word_held:
    assert property (strobe_any |-> !data_valid_n && $stable(data_n)
                     && $stable(group_invert_flag_n) && $stable(data_parity_n))
    else $error("strobe without valid or on a changing word");
  a_parity_match:
    assert property (!data_valid_n |-> data_parity_n == par_exp)
    else $error("parity pins do not match data pins");
  a_invert_half:
    assert property (!data_valid_n |-> inv_ok(data_n, group_invert_flag_n))
    else $error("group sent with more than half its pins low");
  a_bclk_runs:
    assert property (deep_sleep_request_n |-> ##[0:8] (bclk != $past(bclk)))
    else $error("bus clock stopped without deep sleep request");
endmodule

// file: bench/fsb_data_phase_signalling_tb.sv
// Self-checking bench joining the processor end and the chipset end
`timescale 1ns/10ps
module fsb_data_phase_signalling_tb;
  import fsb_pkg::*;
  logic      clk_in, sys_rst_in, tx_valid, sleep_req, dbg_req, deep_sleep_request_n_req, bclk_stop;
  fsb_word_t tx_data, rx_data;
  logic      tx_ready, rx_valid, perr, busy, dbg_seen, xfer_active;
  fsb_pwr_e  pwr;
  fsb_word_t sent[$];
  int        n_errors, checked, rx_idx, wire_idx, k, i;
  logic      busy_seen, bclk_last;
  logic [31:0] seed;

  fsb_if bus ();
  fsb_dev u_fsb_dev (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .sleep_req_in(sleep_req),
    .dbg_reset_req_in(dbg_req), .pwr_state_out(pwr), .xfer_active_out(xfer_active),
    .bus(bus.dev));
  fsb_host u_fsb_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .deep_sleep_request_n_req_in(deep_sleep_request_n_req),
    .bclk_stop_in(bclk_stop), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .parity_err_out(perr), .bus_busy_out(busy), .dbg_reset_seen_out(dbg_seen),
    .bus(bus.host));
  fsb_chk u_fsb_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bclk(bus.bclk),
    .data_bus_busy_n(bus.data_bus_busy_n), .data_valid_n(bus.data_valid_n),
    .data_n(bus.data_n), .data_parity_n(bus.data_parity_n),
    .group_invert_flag_n(bus.group_invert_flag_n), .data_strobe_pos_n(bus.data_strobe_pos_n),
    .data_strobe_neg_n(bus.data_strobe_neg_n), .deep_sleep_request_n(bus.deep_sleep_request_n));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // A group with its flag low travels as the logical word, otherwise inverted
  function automatic fsb_word_t decode(input logic [63:0] d, input logic [3:0] f);
    for (int g = 0; g < 4; g++) decode[16*g +: 16] = f[g] ? ~d[16*g +: 16] : d[16*g +: 16];
  endfunction

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Leaves valid high so back-to-back words need no gap
  task automatic push(input fsb_word_t w);
    tx_data = w;
    tx_valid = 1'b1;
    for (k = 0; k < 400 && tx_ready !== 1'b1; k++) @(negedge clk_in);
    @(negedge clk_in);
    sent.push_back(w);
  endtask

  task automatic final_report();
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(negedge clk_in) begin
    if (!sys_rst_in) begin
      if (rx_valid === 1'b1) begin
        check(rx_idx < sent.size() && rx_data === sent[rx_idx], "received word");
        check(perr === 1'b0, "parity error flagged");
        rx_idx++;
      end
      if (bus.data_strobe_pos_n[0] === 1'b0 || bus.data_strobe_neg_n[0] === 1'b0) begin
        check(wire_idx < sent.size() && decode(bus.data_n, bus.group_invert_flag_n)
              === sent[wire_idx], "word on pins");
        wire_idx++;
      end
      if (busy === 1'b1) busy_seen = 1'b1;
      if (bus.data_valid_n === 1'b0) check(xfer_active === 1'b1, "valid outside busy");
    end
  end

  initial begin
    #800000;
    n_errors++;
    final_report();
  end

  initial begin
    {tx_valid, sleep_req, dbg_req, deep_sleep_request_n_req, bclk_stop} = '0;
    tx_data = '0;
    seed = 32'hD192;
    busy_seen = 1'b0;
    sys_rst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'b0;
    dbg_req = 1'b1;
    @(negedge clk_in);
    check(bus.debug_reset_out_n === 1'b0, "debug reset pin");
    for (i = 0; i < 20 && dbg_seen !== 1'b1; i++) @(negedge clk_in);
    check(dbg_seen === 1'b1, "debug reset not seen");
    dbg_req = 1'b0;
    repeat (4) @(negedge clk_in);
    check(dbg_seen === 1'b0 && bus.debug_reset_out_n === 1'b1, "debug reset stuck");
    // Corner words: all low, all high, groups of exactly 8 and 9 ones, groups of 1 and 15 ones
    push(64'h0000000000000000);
    push(64'hFFFFFFFFFFFFFFFF);
    push(64'h00FF00FF01FF0FF0);
    push(64'h80007FFFFFFE0001);
    for (i = 0; i < 20; i++) push({rnd(), rnd()});
    tx_valid = 1'b0;
    for (i = 0; i < 3000 && rx_idx < 24; i++) @(negedge clk_in);
    check(rx_idx === 24, "words lost in run");
    check(busy_seen === 1'b1, "busy never seen");
    // Half a transfer, idle bus clocks with busy held, then the second half
    for (i = 0; i < 4; i++) push({rnd(), rnd()});
    tx_valid = 1'b0;
    repeat (60) @(negedge clk_in);
    check(rx_idx === 28 && bus.data_valid_n === 1'b1, "half transfer");
    check(bus.data_bus_busy_n === 1'b0, "busy dropped in idle clocks");
    for (i = 0; i < 4; i++) push({rnd(), rnd()});
    tx_valid = 1'b0;
    for (i = 0; i < 200 && rx_idx < 32; i++) @(negedge clk_in);
    check(rx_idx === 32 && wire_idx === 32, "second half lost");
    sleep_req = 1'b1;
    for (i = 0; i < 200 && pwr !== FSB_PWR_SLEEP; i++) @(negedge clk_in);
    check(pwr === FSB_PWR_SLEEP, "sleep not entered");
    for (i = 0; i < 8; i++) push({rnd(), rnd()});
    check(tx_ready === 1'b0, "full buffer accepts word");
    tx_valid = 1'b0;
    repeat (40) @(negedge clk_in);
    check(rx_idx === 32, "data moved while asleep");
    deep_sleep_request_n_req = 1'b1;
    for (i = 0; i < 50 && pwr !== FSB_PWR_DEEP; i++) @(negedge clk_in);
    check(pwr === FSB_PWR_DEEP, "deep sleep not entered");
    bclk_stop = 1'b1;
    repeat (4) @(negedge clk_in);
    bclk_last = bus.bclk;
    repeat (20) @(negedge clk_in);
    check(bus.bclk === bclk_last && pwr === FSB_PWR_DEEP, "deep sleep left early");
    bclk_stop = 1'b0;
    deep_sleep_request_n_req = 1'b0;
    for (i = 0; i < 60 && pwr !== FSB_PWR_SLEEP; i++) @(negedge clk_in);
    check(pwr === FSB_PWR_SLEEP, "deep sleep not left");
    sleep_req = 1'b0;
    for (i = 0; i < 1000 && rx_idx < 40; i++) @(negedge clk_in);
    check(rx_idx === 40 && wire_idx === 40, "buffered words lost");
    final_report();
  end
endmodule
